// ---- src/grl_ctrl.sv ----
/*
 * Device-side remote/local, addressing, clear, trigger and service
 * request control for an instrument bus port.
 * Assumes decoded bus commands arrive as one-cycle pulses from logic on
 * the same clock; the remote-enable and interface-clear lines and the
 * panel keys come from pins and are synchronised here.
 */
`default_nettype none

module grl_ctrl
    import grl_pkg::*;
(
    // Clock and reset.
    input  wire logic       clock,
    input  wire logic       rstn,
    // Bus lines from pins.
    input  wire logic       ren_pin,
    input  wire logic       ifc_pin,
    // Decoded bus commands, one-cycle pulses.
    input  wire logic       cmd_listen,
    input  wire logic       cmd_talk,
    input  wire logic [4:0] cmd_addr,
    input  wire logic       cmd_unlisten,
    input  wire logic       cmd_untalk,
    input  wire logic       cmd_llo,
    input  wire logic       cmd_gtl,
    input  wire logic       cmd_dcl,
    input  wire logic       cmd_sdc,
    input  wire logic       cmd_get,
    input  wire logic       cmd_spe,
    input  wire logic       cmd_spd,
    // Address programming from the menu.
    input  wire logic       addr_wr,
    input  wire logic [4:0] addr_wdata,
    // Instrument status.
    input  wire logic       msg_avail,
    input  wire logic [7:0] sre_mask,
    input  wire logic [7:0] status_in,
    input  wire logic       trig_src_bus,
    // Front panel.
    input  wire logic       key_local_pin,
    input  wire logic [7:0] keys_pin,
    // Outputs.
    output logic [4:0]      bus_address_menu_item,
    output logic            remote_r,
    output logic            lockout_r,
    output logic            listener_active_state,
    output logic            talker_active_r,
    output logic            srq_r,
    output logic            spoll_active_r,
    output logic [7:0]      spoll_byte_r,
    output logic            dev_clear_r,
    output logic            trigger_r,
    output logic [7:0]      keys_r
);

    logic [9:0] sync_q;
    logic       ren_s;
    logic       ifc_s;
    logic       klocal_s;
    logic [6:0] keys_s;

    // Pins pass two flops before any logic reads them.
    grl_sync #(.WIDTH(10)) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .d     ({ren_pin, ifc_pin, key_local_pin, keys_pin[6:0]}),
        .q     (sync_q)
    );

    // Unpack the synchronised pins, in the order they were packed.
    assign ren_s    = sync_q[9];
    assign ifc_s    = sync_q[8];
    assign klocal_s = sync_q[7];
    assign keys_s   = sync_q[6:0];

    // Registered state and the next values that feed it.
    logic         klocal_d_r;
    logic         klocal_d_nxt;
    grl_role_type role_r;
    grl_role_type role_nxt;
    logic [4:0]   addr_nxt;
    logic         remote_nxt;
    logic         lockout_nxt;
    logic         srq_nxt;
    logic         spoll_nxt;
    logic [7:0]   sbyte_nxt;
    logic         clr_nxt;
    logic         trig_nxt;
    logic [7:0]   keys_nxt;
    logic         listen_nxt;
    logic         talk_nxt;
    logic         my_addr;
    logic         local_press;

    // Address match against the programmed address, not the factory value.
    assign my_addr     = (cmd_addr == bus_address_menu_item);
    // Edge detect, so a held local key releases remote once and no more.
    assign local_press = klocal_s & ~klocal_d_r;

    // Next-state logic for addressing, remote/local and bus events.
    always_comb begin
        addr_nxt     = bus_address_menu_item;
        role_nxt     = role_r;
        remote_nxt   = remote_r;
        lockout_nxt  = lockout_r;
        spoll_nxt    = spoll_active_r;
        klocal_d_nxt = klocal_s;
        clr_nxt      = 1'b0;
        trig_nxt     = 1'b0;
        // Out-of-range entries are refused so the bus never sees address 31.
        if (addr_wr && addr_wdata <= GRL_ADDR_MAX) begin
            addr_nxt = addr_wdata;
        end
        // Talking needs no remote state.
        if (cmd_talk && my_addr) begin
            role_nxt = GRL_TALK;
        end else if (cmd_talk && role_r == GRL_TALK) begin
            // Another unit addressed to talk ends this unit's talker role.
            role_nxt = GRL_IDLE;
        end
        // Listen addressing enters remote only with REN already up.
        if (cmd_listen && my_addr) begin
            role_nxt = GRL_LISTEN;
            if (ren_s) begin
                remote_nxt = 1'b1;
            end
        end
        // Unaddressing drops only the role it names.
        if ((cmd_unlisten && role_r == GRL_LISTEN) || (cmd_untalk && role_r == GRL_TALK)) begin
            role_nxt = GRL_IDLE;
        end
        // Lockout may arrive in local too; it bites on the keys at once.
        if (cmd_llo) begin
            lockout_nxt = 1'b1;
        end
        // Go-to-local is an addressed command, so it needs the listener role.
        if (cmd_gtl && role_r == GRL_LISTEN) begin
            remote_nxt  = 1'b0;
            lockout_nxt = 1'b0;
        end
        // Under lockout the local key is dead; only go-to-local or dropping REN frees the panel.
        if (local_press && !lockout_r) begin
            remote_nxt = 1'b0;
        end
        // Dropping REN releases remote and lockout in any case.
        if (!ren_s) begin
            remote_nxt  = 1'b0;
            lockout_nxt = 1'b0;
        end
        // The clear pulse tells the instrument to flush its queues; settings stay.
        if (cmd_dcl || (cmd_sdc && role_r == GRL_LISTEN)) begin
            clr_nxt = 1'b1;
        end
        // A trigger from the bus is dropped unless the bus is the trigger source.
        if (cmd_get && role_r == GRL_LISTEN && trig_src_bus) begin
            trig_nxt = 1'b1;
        end
        // Serial poll mode brackets the status byte read by the controller.
        if (cmd_spe) begin
            spoll_nxt = 1'b1;
        end
        if (cmd_spd) begin
            spoll_nxt = 1'b0;
        end
        // Interface clear wins; settings and data are not touched here.
        if (ifc_s) begin
            role_nxt   = GRL_IDLE;
            remote_nxt = 1'b0;
            spoll_nxt  = 1'b0;
        end
        // Role flags are decoded here so the outputs leave straight from flops.
        listen_nxt = (role_nxt == GRL_LISTEN);
        talk_nxt   = (role_nxt == GRL_TALK);
    end

    // Status byte, service request and panel key gating.
    always_comb begin
        srq_nxt   = msg_avail & sre_mask[GRL_MAV_BIT];
        sbyte_nxt = status_in;
        // The request bit tracks the value the line will show next cycle.
        sbyte_nxt[GRL_RQS_BIT] = srq_nxt;
        // The local key only answers to lockout; remote alone leaves it live.
        keys_nxt  = {klocal_s & ~lockout_r, keys_s};
        // Remote gates all keys but local; power is not on this path.
        if (remote_r || lockout_r) begin
            keys_nxt[6:0] = 7'h00;
        end
    end

    // Every state bit and output is registered here, apart from the pin synchroniser flops in u_sync.
    always_ff @(posedge clock) begin
        if (!rstn) begin
            bus_address_menu_item <= GRL_ADDR_DEFAULT;
            role_r                <= GRL_IDLE;
            remote_r              <= 1'b0;
            lockout_r             <= 1'b0;
            spoll_active_r        <= 1'b0;
            klocal_d_r            <= 1'b0;
            dev_clear_r           <= 1'b0;
            trigger_r             <= 1'b0;
            srq_r                 <= 1'b0;
            spoll_byte_r          <= 8'h00;
            keys_r                <= 8'h00;
            listener_active_state <= 1'b0;
            talker_active_r       <= 1'b0;
        end else begin
            bus_address_menu_item <= addr_nxt;
            role_r                <= role_nxt;
            remote_r              <= remote_nxt;
            lockout_r             <= lockout_nxt;
            spoll_active_r        <= spoll_nxt;
            klocal_d_r            <= klocal_d_nxt;
            dev_clear_r           <= clr_nxt;
            trigger_r             <= trig_nxt;
            srq_r                 <= srq_nxt;
            spoll_byte_r          <= sbyte_nxt;
            keys_r                <= keys_nxt;
            listener_active_state <= listen_nxt;
            talker_active_r       <= talk_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- src/grl_pkg.sv ----
/*
 * Constants and types for the bus remote/local control block.
 * Assumes a single 40 MHz clock domain and a synchronous active-low reset.
 */
// Behaviour
// - REN alone changes nothing; remote is entered on next listen addressing.
// - Talker addressing works in local and in remote alike.
// - In remote only local key and power act; local key restores local unless locked.
// - Interface clear drops talker and listener to idle and returns to local.
// - Interface clear leaves settings, data and event registers untouched.
// - Go-to-local leaves remote, re-enables keys and clears lockout.
// - Primary address is 0 to 30, factory default 16.
// - Message available bit enabled in request mask raises SRQ when output ready.
// - Unaddressed device clear returns the interface to a known condition.
// - Selective device clear does the same only when this device is addressed listener.
// - Device clear empties buffers, cancels deferred work, keeps settings and data.
// - Group trigger fires only when bus trigger is the selected source.
// - Status byte is returned on serial poll at any time.
`default_nettype none

package grl_pkg;

    // Primary address range and factory value.
    localparam logic [4:0] GRL_ADDR_MAX     = 5'h1e;
    localparam logic [4:0] GRL_ADDR_DEFAULT = 5'h10;

    // Service request enable bit position of the message-available bit.
    localparam int         GRL_MAV_BIT      = 4;
    // Request-service bit position in the returned status byte.
    localparam int         GRL_RQS_BIT      = 6;

    // Minimum interface clear hold time, for reference by the bench.
    localparam int         GRL_IFC_MIN_NS   = 100000;
    localparam int         GRL_CLK_NS       = 25;
    localparam int         GRL_IFC_MIN_CYC  = (GRL_IFC_MIN_NS + GRL_CLK_NS - 1) / GRL_CLK_NS;

    // Bus-side addressing role.
    typedef enum logic [1:0] {
        GRL_IDLE,
        GRL_LISTEN,
        GRL_TALK
    } grl_role_type;

endpackage

`default_nettype wire

// ---- src/grl_sync.sv ----
/*
 * Two-flip-flop synchroniser, one per bit of a bus of levels.
 * Assumes inputs arrive asynchronously to clock.
 */
`default_nettype none

module grl_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clock,
    input  wire logic             rstn,
    // Levels.
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] q_nxt;

    // Only the second stage reads the first, to contain metastability.
    always_comb begin
        meta_nxt = d;
        q_nxt    = meta_r;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= meta_nxt;
            q      <= q_nxt;
        end
    end

endmodule

`default_nettype wire

// ---- test/grl_chk.sv ----
/*
 * Assertions for grl_ctrl, bound to its ports.
 * Assumes one clock and the synchronous active-low reset rstn.
 */
`default_nettype none
module grl_chk
    import grl_pkg::*;
(
    // Clock and reset.
    input wire logic       clock,
    input wire logic       rstn,
    // Inputs of the block.
    input wire logic       ifc_pin,
    input wire logic       cmd_listen,
    input wire logic       cmd_gtl,
    input wire logic       cmd_dcl,
    input wire logic       cmd_sdc,
    input wire logic       cmd_get,
    input wire logic       trig_src_bus,
    input wire logic       msg_avail,
    input wire logic [4:0] cmd_addr,
    input wire logic [7:0] sre_mask,
    // Outputs of the block.
    input wire logic [4:0] bus_address_menu_item,
    input wire logic [7:0] keys_r,
    input wire logic       remote_r,
    input wire logic       lockout_r,
    input wire logic       listener_active_state,
    input wire logic       talker_active_r,
    input wire logic       srq_r,
    input wire logic       trigger_r,
    input wire logic       dev_clear_r
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    AST_ADDR_RANGE: assert property (bus_address_menu_item <= GRL_ADDR_MAX)
        else $error("address out of range");
    AST_REMOTE_ENTRY: assert property ($rose(remote_r) |-> $past(cmd_listen))
        else $error("remote without listen");
    AST_LISTEN_MATCH: assert property ($rose(listener_active_state)
        |-> $past(cmd_listen && cmd_addr == bus_address_menu_item))
        else $error("listen on foreign address");
    AST_IFC_IDLE: assert property (ifc_pin [*4]
        |-> !talker_active_r && !listener_active_state && !remote_r)
        else $error("clear left a role");
    AST_TRIG: assert property (trigger_r
        |-> $past(cmd_get && trig_src_bus && listener_active_state))
        else $error("stray trigger");
    AST_SRQ: assert property ($past(rstn) |-> srq_r == $past(msg_avail && sre_mask[GRL_MAV_BIT]))
        else $error("request line wrong");
    AST_DCLR: assert property (dev_clear_r
        |-> $past(cmd_dcl || cmd_sdc && listener_active_state))
        else $error("stray device clear");
    AST_GTL: assert property (cmd_gtl && listener_active_state |=> !remote_r && !lockout_r)
        else $error("local not restored");
    AST_LOCK_KEY: assert property (lockout_r && $past(lockout_r) |-> !keys_r[7])
        else $error("local key live under lockout");
    // Remote leaves only the local key live on the panel.
    AST_REMOTE_KEYS: assert property (remote_r |=> keys_r[6:0] == 7'h00)
        else $error("panel key live in remote");
endmodule
bind grl_ctrl grl_chk u_chk (.*);
`default_nettype wire

// ---- test/grl_host.sv ----
/* Bus controller stand-in that drives interface clear.
   Assumes go is a one-cycle request from the bench. */
`default_nettype none
module grl_host #(
    parameter int CYC = 4
) (
    input  wire logic clock,
    input  wire logic go,
    output var logic  ifc_pin = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    // The line is held a full minimum time, never cut short.
    always @(posedge clock) begin
        if (go) n <= CYC;
        else if (n > 0) n <= n - 1;
        ifc_pin <= go || n > 1;
    end
endmodule
`default_nettype wire

// ---- test/gpib_remote_local_control_tb.sv ----
/* Directed bench for grl_ctrl with a host model for interface clear.
   Assumes the one-cycle command latency of the block. */
`default_nettype none
module gpib_remote_local_control_tb
    import grl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 0, rstn = 0, ren_pin = 0, addr_wr = 0, msg_avail = 0;
    logic trig_src_bus = 0, key_local_pin = 0, ifc_go = 0, ifc_pin;
    logic [4:0] cmd_addr = 0, addr_wdata = 0, bus_address_menu_item;
    logic [7:0] sre_mask = 0, status_in = 0, keys_pin = 0, spoll_byte_r, keys_r;
    logic [10:0] c = 0;
    logic remote_r, lockout_r, listener_active_state, talker_active_r, srq_r;
    logic spoll_active_r, dev_clear_r, trigger_r;
    wire cmd_listen, cmd_talk, cmd_unlisten, cmd_untalk, cmd_llo, cmd_gtl;
    wire cmd_dcl, cmd_sdc, cmd_get, cmd_spe, cmd_spd;
    int mismatches = 0, n_checks = 0;
    assign {cmd_spd, cmd_spe, cmd_get, cmd_sdc, cmd_dcl, cmd_gtl, cmd_llo,
            cmd_untalk, cmd_unlisten, cmd_talk, cmd_listen} = c;
    grl_ctrl dut (.*);
    grl_host #(.CYC(GRL_IFC_MIN_CYC)) host (.clock, .go(ifc_go), .ifc_pin);
    // Free-running 40 MHz clock.
    always #12.5 clock = ~clock;

    task automatic ck(input logic [7:0] s, e, input string n);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("Error %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // Bit index: 0 listen 1 talk 2 unl 4 llo 5 gtl 6 dcl 7 sdc 8 get 9 spe 10 spd.
    task automatic cmd(input int i, input logic [4:0] a = 5'h10);
        @(posedge clock);
        c        <= 11'h1 << i;
        cmd_addr <= a;
        @(posedge clock);
        c <= '0;
        #1;
    endtask
    task automatic pins(input logic k, input logic [7:0] p);
        @(posedge clock);
        key_local_pin <= k;
        keys_pin      <= p;
        wt(4);
    endtask
    task automatic waddr(input logic [4:0] a);
        @(posedge clock);
        addr_wr    <= 1;
        addr_wdata <= a;
        @(posedge clock);
        addr_wr <= 0;
        #1;
    endtask
    task automatic t_remote;
        @(posedge clock) ren_pin <= 1;
        wt(4);
        ck(remote_r, 0, "ren only");
        cmd(1);
        ck(talker_active_r, 1, "talk local");
        cmd(3);
        ck(talker_active_r, 0, "untalk");
        cmd(0);
        ck(remote_r, 1, "remote");
        pins(0, 8'h7f);
        ck(keys_r, 0, "keys gated");
        pins(1, 8'h7f);
        ck(remote_r, 0, "local key");
        ck(keys_r, 8'hff, "keys live");
        pins(0, 0);
    endtask
    task automatic t_lock;
        cmd(0);
        cmd(4);
        pins(1, 0);
        ck(remote_r, 1, "locked remote");
        ck(keys_r[7], 0, "locked key");
        pins(0, 0);
        cmd(5);
        ck({remote_r, lockout_r}, 0, "gtl");
    endtask
    task automatic t_ifc;
        cmd(0);
        cmd(1);
        ck({talker_active_r, remote_r}, 8'h03, "talk remote");
        @(posedge clock) ifc_go <= 1;
        @(posedge clock) ifc_go <= 0;
        wt(GRL_IFC_MIN_CYC + 4);
        ck({talker_active_r, listener_active_state, remote_r}, 0, "ifc");
        ck(bus_address_menu_item, 5'h10, "ifc addr");
    endtask
    task automatic t_addr;
        waddr(5'h1f);
        ck(bus_address_menu_item, 5'h10, "addr 31");
        waddr(5'h1e);
        ck(bus_address_menu_item, 5'h1e, "addr 30");
        // Address 16 now stands for another unit, never a second holder of 30.
        cmd(0);
        ck(listener_active_state, 0, "foreign");
        waddr(5'h10);
    endtask
    task automatic t_trig;
        cmd(0);
        cmd(8);
        ck(trigger_r, 0, "get off");
        @(posedge clock) trig_src_bus <= 1;
        cmd(8);
        ck(trigger_r, 1, "get on");
        cmd(6);
        ck(dev_clear_r, 1, "dcl");
        cmd(7);
        ck(dev_clear_r, 1, "sdc");
        cmd(2);
        cmd(7);
        ck(dev_clear_r, 0, "sdc unaddr");
        cmd(6);
        ck(dev_clear_r, 1, "dcl unaddr");
    endtask
    task automatic t_srq;
        @(posedge clock) status_in <= 8'h05;
        cmd(9);
        ck(spoll_byte_r, 8'h05, "poll idle");
        ck(spoll_active_r, 1, "poll on");
        cmd(10);
        ck(spoll_active_r, 0, "poll off");
        @(posedge clock) msg_avail <= 1;
        wt(3);
        ck(srq_r, 0, "srq masked");
        @(posedge clock) sre_mask <= 8'h10;
        // The host waits for the request line, not a fixed delay.
        for (int i = 0; i < 8 && srq_r !== 1'b1; i++) wt(1);
        ck(srq_r, 1, "srq");
        cmd(9);
        ck(spoll_byte_r, 8'h45, "poll srq");
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Main sequence after two reset cycles.
    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1;
        wt(1);
        ck(bus_address_menu_item, 5'h10, "reset addr");
        t_remote;
        t_lock;
        t_ifc;
        t_addr;
        t_trig;
        t_srq;
        summarize;
    end
    // Watchdog well past the expected run length.
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        summarize;
    end
endmodule
`default_nettype wire
